// ---- core/rcc_defs.vh ----
// constants for the reset and clock controller
`ifndef RCC_DEFS_VH
`define RCC_DEFS_VH
`define RCC_A_CLK 12'h000
`define RCC_A_DIV 12'h004
`define RCC_A_TICK 12'h008
`define RCC_A_APLL 12'h00c
`define RCC_A_RST 12'h010
`define RCC_A_STAT 12'h014
`define RCC_F_SEL 1:0
`define RCC_F_PFS 2
`define RCC_F_PER 4:3
`define RCC_F_LED 6:5
`define RCC_F_PREDIV 9:0
`define RCC_F_XTICK 7:0
`define RCC_F_OTICK 15:8
`define RCC_F_FLO 7:0
`define RCC_F_FHI 15:8
`define RCC_F_INT 21:16
`define RCC_F_ODIV 26:22
`define RCC_F_FON 27
`define RCC_F_FOFF 28
`define RCC_F_SWSYS 0
`define RCC_F_SWCPU 1
`define RCC_F_BODCHIP 2
`define RCC_F_CAUSE 5:0
`define RCC_F_ASEL 7:6
`define RCC_F_APU 8
`define RCC_PREDIV_RST 10'h001
`define RCC_XTICK_RST 8'h27
`define RCC_OTICK_RST 8'h07
`define RCC_SRC_XTAL 2'h0
`define RCC_SRC_PLL 2'h1
`define RCC_SRC_OSC 2'h2
`define RCC_SRC_APLL 2'h3
`define RCC_PER_0 2'h0
`define RCC_PER_1 2'h1
`define RCC_PER_2 2'h2
`define RCC_LED_OFF 2'h0
`define RCC_LED_APB 2'h1
`define RCC_LED_OSC 2'h2
`define RCC_LED_XTAL 2'h3
`define RCC_R2 11'h002
`define RCC_R3 11'h003
`define RCC_R4 11'h004
`define RCC_R6 11'h006
`define RCC_R8 11'h008
`define RCC_ONE11 11'h001
`define RCC_ONE9 9'h001
`define RCC_OSC_D256 9'h100
`define RCC_C_NONE 6'h00
`define RCC_C_CHIP 6'h01
`define RCC_C_BOD_SYS 6'h0f
`define RCC_C_RWDT_SYS 6'h10
`define RCC_C_GLITCH 6'h13
`define RCC_C_SW_SYS 6'h03
`define RCC_C_SLEEP 6'h05
`define RCC_C_MWDT0_G 6'h07
`define RCC_C_MWDT1_G 6'h08
`define RCC_C_RWDT_CORE 6'h09
`define RCC_C_MWDT0_CPU 6'h0b
`define RCC_C_SW_CPU 6'h0c
`define RCC_C_RWDT_CPU 6'h0d
`define RCC_C_MWDT1_CPU 6'h11
`define RCC_L_NONE 3'h0
`define RCC_L_CPU 3'h1
`define RCC_L_CORE 3'h2
`define RCC_L_SYS 3'h3
`define RCC_L_CHIP 3'h4
`define RCC_RST_HOLD 6'h10
`define RCC_CNT0 6'h00
`define RCC_CNT1 6'h01
`endif

// ---- core/rcc_top.v ----
// reset sequencer, clock select and dividers with apb registers
// Summary of operation
// - processor reset touches only the processor
// - core reset spares the always-on domain
// - system reset includes always-on; chip resets all
// - memory kept except on chip reset
// - any reset hits processor; cause readable
// - power-on, brown-out in chip mode, super watchdog give 0x01
// - brown-out gives system or chip reset
// - source select: crystal, pll, osc, audio
// - crystal/osc divided by pre-divider plus one
// - pll 480 divided by 6, 3, 2
// - pll 320 divided by 4, 2
// - audio pll divided by 4 or 2
// - bus clock 80, half, or equal cpu
// - tick from crystal, or from oscillator
// - tick dividers default 39 and 7
// - led clock: off, bus, osc, crystal
// - led osc path survives bus clock gating
// - slow osc clock is osc over 256
// - force-off wins, then force-on; else follows sleep state
`include "rcc_defs.vh"

// pin sampler: three flops, change accepted when second and third agree
module rcc_sync (
  input wire clk,
  input wire rstn,
  input wire pin,
  output reg lvl_q,
  output wire chg,
  output wire rise
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  assign chg = (s2_q == s3_q) && (s3_q != lvl_q);
  assign rise = chg & s3_q;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (chg) begin
        lvl_q <= s3_q;
      end
    end
  end
endmodule // rcc_sync

// divide by ratio counting both source edges; fall marks a period boundary
module rcc_div #(
  parameter W = 11
) (
  input wire pclk,
  input wire presetn,
  input wire step,
  input wire restart,
  input wire [W-1:0] ratio,
  output reg clk_q,
  output wire fall
);
  reg [W-1:0] cnt_q;
  wire last;
  assign last = ({1'b0, cnt_q} + {{W{1'b0}}, 1'b1}) >= {1'b0, ratio};
  // restart is built from fall outside, so fall must not read it back
  assign fall = step & last & clk_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      clk_q <= 1'b0;
    end else if (restart) begin
      cnt_q <= {W{1'b0}};
      clk_q <= 1'b0;
    end else if (step) begin
      if (last) begin
        cnt_q <= {W{1'b0}};
        clk_q <= ~clk_q;
      end else begin
        cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // rcc_div

module rcc_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire xtal_clk,
  input wire pll_clk,
  input wire osc_8mhz_clock,
  input wire audio_pll_clock,
  input wire brownout_det,
  input wire super_wdt_rst,
  input wire rwdt_sys_rst,
  input wire glitch_rst,
  input wire sleep_wake_rst,
  input wire mwdt0_glb_rst,
  input wire mwdt1_glb_rst,
  input wire rwdt_core_rst,
  input wire mwdt0_cpu_rst,
  input wire rwdt_cpu_rst,
  input wire mwdt1_cpu_rst,
  input wire sleep_mode,
  input wire low_power_mode,
  output reg cpu_rst_n,
  output reg core_rst_n,
  output reg sys_rst_n,
  output reg chip_rst_n,
  output reg mem_rst_n,
  output wire cpu_clock,
  output reg apb_clock,
  output wire ref_tick,
  output reg led_pwm_clock,
  output wire osc_8mhz_div256_clock,
  output reg audio_pll_power_on,
  output reg [7:0] fraction_low,
  output reg [7:0] fraction_high,
  output reg [5:0] integer_part,
  output reg [4:0] audio_pll_out_div
);
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_HOLD = 2'b10;

  // configuration registers
  reg [1:0] src_sel_q;
  reg pll_frequency_select;
  reg [1:0] cpu_period_select;
  reg [1:0] led_pwm_clock_select;
  reg [9:0] pre_divider_count;
  reg [7:0] crystal_tick_divider;
  reg [7:0] oscillator_tick_divider;
  reg audio_pll_force_on;
  reg audio_pll_force_off;
  reg brownout_chip_mode;
  reg software_system_reset;
  reg software_processor_reset;

  // source pins are sampled on pclk; they must run well below pclk / 2
  wire xtal_lvl, xtal_chg, osc_lvl, osc_chg, pll_chg, apll_chg, bod_rise, swd_rise;
  rcc_sync u_sx (.clk(pclk), .rstn(presetn), .pin(xtal_clk), .lvl_q(xtal_lvl),
    .chg(xtal_chg), .rise());
  rcc_sync u_so (.clk(pclk), .rstn(presetn), .pin(osc_8mhz_clock), .lvl_q(osc_lvl),
    .chg(osc_chg), .rise());
  rcc_sync u_sp (.clk(pclk), .rstn(presetn), .pin(pll_clk), .lvl_q(),
    .chg(pll_chg), .rise());
  rcc_sync u_sa (.clk(pclk), .rstn(presetn), .pin(audio_pll_clock), .lvl_q(),
    .chg(apll_chg), .rise());
  rcc_sync u_sb (.clk(pclk), .rstn(presetn), .pin(brownout_det), .lvl_q(),
    .chg(), .rise(bod_rise));
  rcc_sync u_sw (.clk(pclk), .rstn(presetn), .pin(super_wdt_rst), .lvl_q(),
    .chg(), .rise(swd_rise));

  // reset request arbitration: the widest scope wins
  reg [2:0] req_lvl;
  reg [5:0] req_code;
  always @* begin
    req_lvl = `RCC_L_NONE;
    req_code = `RCC_C_NONE;
    if (mwdt1_cpu_rst) begin
      req_lvl = `RCC_L_CPU; req_code = `RCC_C_MWDT1_CPU;
    end
    if (rwdt_cpu_rst) begin
      req_lvl = `RCC_L_CPU; req_code = `RCC_C_RWDT_CPU;
    end
    if (software_processor_reset) begin
      req_lvl = `RCC_L_CPU; req_code = `RCC_C_SW_CPU;
    end
    if (mwdt0_cpu_rst) begin
      req_lvl = `RCC_L_CPU; req_code = `RCC_C_MWDT0_CPU;
    end
    if (rwdt_core_rst) begin
      req_lvl = `RCC_L_CORE; req_code = `RCC_C_RWDT_CORE;
    end
    if (mwdt1_glb_rst) begin
      req_lvl = `RCC_L_CORE; req_code = `RCC_C_MWDT1_G;
    end
    if (mwdt0_glb_rst) begin
      req_lvl = `RCC_L_CORE; req_code = `RCC_C_MWDT0_G;
    end
    if (sleep_wake_rst) begin
      req_lvl = `RCC_L_CORE; req_code = `RCC_C_SLEEP;
    end
    if (software_system_reset) begin
      req_lvl = `RCC_L_CORE; req_code = `RCC_C_SW_SYS;
    end
    if (glitch_rst) begin
      req_lvl = `RCC_L_SYS; req_code = `RCC_C_GLITCH;
    end
    if (rwdt_sys_rst) begin
      req_lvl = `RCC_L_SYS; req_code = `RCC_C_RWDT_SYS;
    end
    if (bod_rise && !brownout_chip_mode) begin
      req_lvl = `RCC_L_SYS; req_code = `RCC_C_BOD_SYS;
    end
    if ((bod_rise && brownout_chip_mode) || swd_rise) begin
      req_lvl = `RCC_L_CHIP; req_code = `RCC_C_CHIP;
    end
  end

  // reset sequencer
  reg [1:0] st_q, st_d;
  reg [2:0] lvl_q, lvl_d;
  reg [5:0] cnt_q, cnt_d;
  reg [5:0] cause_q, cause_d;
  always @* begin
    st_d = st_q;
    lvl_d = lvl_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    case (st_q)
      S_HOLD: begin
        if (cnt_q == `RCC_CNT0) begin
          st_d = S_IDLE;
          lvl_d = `RCC_L_NONE;
        end else begin
          cnt_d = cnt_q - `RCC_CNT1;
        end
      end
      S_IDLE: begin
        lvl_d = `RCC_L_NONE;
      end
      default: begin
        st_d = S_IDLE;
        lvl_d = `RCC_L_NONE;
      end
    endcase
    // a new request at equal or wider scope restarts the hold and overwrites the cause
    if (req_lvl != `RCC_L_NONE && req_lvl >= lvl_q) begin
      st_d = S_HOLD;
      lvl_d = req_lvl;
      cnt_d = `RCC_RST_HOLD;
      cause_d = req_code;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_HOLD;
      lvl_q <= `RCC_L_CHIP;
      cnt_q <= `RCC_RST_HOLD;
      cause_q <= `RCC_C_CHIP;
      cpu_rst_n <= 1'b0;
      core_rst_n <= 1'b0;
      sys_rst_n <= 1'b0;
      chip_rst_n <= 1'b0;
      mem_rst_n <= 1'b0;
    end else begin
      st_q <= st_d;
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      cpu_rst_n <= (lvl_d == `RCC_L_NONE);
      core_rst_n <= (lvl_d < `RCC_L_CORE);
      sys_rst_n <= (lvl_d < `RCC_L_SYS);
      chip_rst_n <= (lvl_d != `RCC_L_CHIP);
      mem_rst_n <= (lvl_d != `RCC_L_CHIP);
    end
  end

  // apb slave: zero wait states, data captured during setup
  wire hit;
  wire wr;
  reg [31:0] rdata;
  assign hit = (paddr == `RCC_A_CLK) || (paddr == `RCC_A_DIV) || (paddr == `RCC_A_TICK) ||
    (paddr == `RCC_A_APLL) || (paddr == `RCC_A_RST) || (paddr == `RCC_A_STAT);
  assign wr = psel & penable & pwrite & hit;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  reg [1:0] act_sel_q;
  always @* begin
    rdata = 32'h0000_0000;
    case (paddr)
      `RCC_A_CLK: begin
        rdata[`RCC_F_SEL] = src_sel_q;
        rdata[`RCC_F_PFS] = pll_frequency_select;
        rdata[`RCC_F_PER] = cpu_period_select;
        rdata[`RCC_F_LED] = led_pwm_clock_select;
      end
      `RCC_A_DIV: rdata[`RCC_F_PREDIV] = pre_divider_count;
      `RCC_A_TICK: begin
        rdata[`RCC_F_XTICK] = crystal_tick_divider;
        rdata[`RCC_F_OTICK] = oscillator_tick_divider;
      end
      `RCC_A_APLL: begin
        rdata[`RCC_F_FLO] = fraction_low;
        rdata[`RCC_F_FHI] = fraction_high;
        rdata[`RCC_F_INT] = integer_part;
        rdata[`RCC_F_ODIV] = audio_pll_out_div;
        rdata[`RCC_F_FON] = audio_pll_force_on;
        rdata[`RCC_F_FOFF] = audio_pll_force_off;
      end
      `RCC_A_RST: rdata[`RCC_F_BODCHIP] = brownout_chip_mode;
      `RCC_A_STAT: begin
        rdata[`RCC_F_CAUSE] = cause_q;
        rdata[`RCC_F_ASEL] = act_sel_q;
        rdata[`RCC_F_APU] = audio_pll_power_on;
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  // digital config is cleared by core and wider resets, always-on bits only by system and chip
  wire dig_clr;
  wire aon_clr;
  assign dig_clr = (lvl_q >= `RCC_L_CORE);
  assign aon_clr = (lvl_q >= `RCC_L_SYS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_q <= `RCC_SRC_XTAL;
      pll_frequency_select <= 1'b0;
      cpu_period_select <= `RCC_PER_0;
      led_pwm_clock_select <= `RCC_LED_OFF;
      pre_divider_count <= `RCC_PREDIV_RST;
      crystal_tick_divider <= `RCC_XTICK_RST;
      oscillator_tick_divider <= `RCC_OTICK_RST;
      software_system_reset <= 1'b0;
      software_processor_reset <= 1'b0;
    end else if (dig_clr) begin
      src_sel_q <= `RCC_SRC_XTAL;
      pll_frequency_select <= 1'b0;
      cpu_period_select <= `RCC_PER_0;
      led_pwm_clock_select <= `RCC_LED_OFF;
      pre_divider_count <= `RCC_PREDIV_RST;
      crystal_tick_divider <= `RCC_XTICK_RST;
      oscillator_tick_divider <= `RCC_OTICK_RST;
      software_system_reset <= 1'b0;
      software_processor_reset <= 1'b0;
    end else begin
      software_system_reset <= wr && paddr == `RCC_A_RST && pwdata[`RCC_F_SWSYS];
      software_processor_reset <= wr && paddr == `RCC_A_RST && pwdata[`RCC_F_SWCPU];
      if (wr && paddr == `RCC_A_CLK) begin
        src_sel_q <= pwdata[`RCC_F_SEL];
        pll_frequency_select <= pwdata[`RCC_F_PFS];
        cpu_period_select <= pwdata[`RCC_F_PER];
        led_pwm_clock_select <= pwdata[`RCC_F_LED];
      end
      if (wr && paddr == `RCC_A_DIV) begin
        pre_divider_count <= pwdata[`RCC_F_PREDIV];
      end
      if (wr && paddr == `RCC_A_TICK) begin
        crystal_tick_divider <= pwdata[`RCC_F_XTICK];
        oscillator_tick_divider <= pwdata[`RCC_F_OTICK];
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fraction_low <= 8'h00;
      fraction_high <= 8'h00;
      integer_part <= 6'h00;
      audio_pll_out_div <= 5'h00;
      audio_pll_force_on <= 1'b0;
      audio_pll_force_off <= 1'b0;
      brownout_chip_mode <= 1'b0;
      audio_pll_power_on <= 1'b0;
    end else begin
      // force-off has priority; with neither forced the pll tracks sleep
      audio_pll_power_on <= ~audio_pll_force_off &
        (audio_pll_force_on | ~sleep_mode);
      if (aon_clr) begin
        fraction_low <= 8'h00;
        fraction_high <= 8'h00;
        integer_part <= 6'h00;
        audio_pll_out_div <= 5'h00;
        audio_pll_force_on <= 1'b0;
        audio_pll_force_off <= 1'b0;
        brownout_chip_mode <= 1'b0;
      end else begin
        // field widths bound the values; numerator range is software's job
        if (wr && paddr == `RCC_A_APLL) begin
          fraction_low <= pwdata[`RCC_F_FLO];
          fraction_high <= pwdata[`RCC_F_FHI];
          integer_part <= pwdata[`RCC_F_INT];
          audio_pll_out_div <= pwdata[`RCC_F_ODIV];
          audio_pll_force_on <= pwdata[`RCC_F_FON];
          audio_pll_force_off <= pwdata[`RCC_F_FOFF];
        end
        if (wr && paddr == `RCC_A_RST) begin
          brownout_chip_mode <= pwdata[`RCC_F_BODCHIP];
        end
      end
    end
  end

  // ratios wanted by the programmed selection, in source edges per half period
  reg [10:0] cpu_n;
  reg [10:0] apb_n;
  always @* begin
    cpu_n = {1'b0, pre_divider_count} + `RCC_ONE11;
    apb_n = cpu_n;
    case (src_sel_q)
      `RCC_SRC_PLL: begin
        if (pll_frequency_select) begin
          apb_n = `RCC_R6;
          if (cpu_period_select == `RCC_PER_0) begin
            cpu_n = `RCC_R6;
          end else if (cpu_period_select == `RCC_PER_1) begin
            cpu_n = `RCC_R3;
          end else begin
            cpu_n = `RCC_R2;
          end
        end else begin
          apb_n = `RCC_R4;
          cpu_n = (cpu_period_select == `RCC_PER_0) ? `RCC_R4 : `RCC_R2;
        end
      end
      `RCC_SRC_APLL: begin
        cpu_n = (cpu_period_select == `RCC_PER_0) ? `RCC_R4 : `RCC_R2;
        apb_n = (cpu_period_select == `RCC_PER_0) ? `RCC_R8 : `RCC_R4;
      end
      default: begin
        cpu_n = {1'b0, pre_divider_count} + `RCC_ONE11;
        apb_n = cpu_n;
      end
    endcase
  end

  // a new selection is applied only as the cpu clock falls, so the low phase
  // starts clean; a stopped old source therefore blocks the switch
  reg [10:0] act_cpu_n_q;
  reg [10:0] act_apb_n_q;
  reg src_step;
  wire cpu_fall;
  wire apply;
  wire apb_div;
  assign apply = cpu_fall &&
    (src_sel_q != act_sel_q || cpu_n != act_cpu_n_q || apb_n != act_apb_n_q);
  always @* begin
    case (act_sel_q)
      `RCC_SRC_XTAL: src_step = xtal_chg;
      `RCC_SRC_PLL: src_step = pll_chg;
      `RCC_SRC_OSC: src_step = osc_chg;
      `RCC_SRC_APLL: src_step = apll_chg;
      default: src_step = xtal_chg;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_sel_q <= `RCC_SRC_XTAL;
      act_cpu_n_q <= `RCC_R2;
      act_apb_n_q <= `RCC_R2;
    end else if (apply) begin
      act_sel_q <= src_sel_q;
      act_cpu_n_q <= cpu_n;
      act_apb_n_q <= apb_n;
    end
  end

  rcc_div #(.W(11)) u_cpu (.pclk(pclk), .presetn(presetn), .step(src_step),
    .restart(apply), .ratio(act_cpu_n_q), .clk_q(cpu_clock), .fall(cpu_fall));
  rcc_div #(.W(11)) u_apb (.pclk(pclk), .presetn(presetn), .step(src_step),
    .restart(apply), .ratio(act_apb_n_q), .clk_q(apb_div), .fall());

  // reference tick keeps its rate across source changes
  wire ref_osc;
  wire [8:0] ref_n;
  assign ref_osc = (act_sel_q == `RCC_SRC_OSC);
  assign ref_n = ref_osc ? ({1'b0, oscillator_tick_divider} + `RCC_ONE9) :
    ({1'b0, crystal_tick_divider} + `RCC_ONE9);
  rcc_div #(.W(9)) u_ref (.pclk(pclk), .presetn(presetn),
    .step(ref_osc ? osc_chg : xtal_chg), .restart(apply), .ratio(ref_n),
    .clk_q(ref_tick), .fall());
  rcc_div #(.W(9)) u_d256 (.pclk(pclk), .presetn(presetn), .step(osc_chg),
    .restart(1'b0), .ratio(`RCC_OSC_D256), .clk_q(osc_8mhz_div256_clock),
    .fall());

  // led clock: osc path does not pass through the bus clock gate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_clock <= 1'b0;
      led_pwm_clock <= 1'b0;
    end else begin
      apb_clock <= apb_div & ~low_power_mode;
      case (led_pwm_clock_select)
        `RCC_LED_APB: led_pwm_clock <= apb_div & ~low_power_mode;
        `RCC_LED_OSC: led_pwm_clock <= osc_lvl;
        `RCC_LED_XTAL: led_pwm_clock <= xtal_lvl;
        default: led_pwm_clock <= 1'b0;
      endcase
    end
  end
endmodule // rcc_top

// ---- verif/rcc_assertions.sv ----
// concurrent checks on reset scopes and register bus refusal
module rcc_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pslverr,
  input wire pready,
  input wire super_wdt_rst,
  input wire rwdt_sys_rst,
  input wire rwdt_core_rst,
  input wire mwdt0_cpu_rst,
  input wire cpu_rst_n,
  input wire core_rst_n,
  input wire sys_rst_n,
  input wire chip_rst_n,
  input wire mem_rst_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_cpu_only:
    assert property (mwdt0_cpu_rst && core_rst_n && !rwdt_core_rst && !rwdt_sys_rst
      |=> !cpu_rst_n && core_rst_n) else $error("cpu request widened");
  a_core_scope:
    assert property (rwdt_core_rst && sys_rst_n && !rwdt_sys_rst
      |=> !core_rst_n && !cpu_rst_n && sys_rst_n) else $error("core scope wrong");
  a_sys_scope:
    assert property (rwdt_sys_rst && chip_rst_n
      |=> !sys_rst_n && !core_rst_n && chip_rst_n && mem_rst_n) else $error("system scope wrong");
  a_chip_all:
    assert property ($fell(chip_rst_n) |-> !mem_rst_n && !sys_rst_n && !core_rst_n && !cpu_rst_n)
      else $error("chip reset partial");
  a_mem_kept:
    assert property ($fell(mem_rst_n) |-> $fell(chip_rst_n)) else $error("memory reset alone");
  // a held reset must also end, or the core never restarts
  a_hold_low:
    assert property ($fell(cpu_rst_n) |=> !cpu_rst_n [*8] ##[1:30] cpu_rst_n)
      else $error("cpu reset hold wrong");
  a_wdt_chip:
    assert property ($rose(super_wdt_rst) |-> ##[1:8] !chip_rst_n) else $error("no chip reset");
  a_unmapped_err:
    assert property (psel && penable |-> pready && pslverr == (paddr > 12'h014))
      else $error("bus error flag wrong");
endmodule // rcc_checker

bind rcc_top rcc_checker i_rcc_checker (.*);

// ---- verif/rcc_top_tb.sv ----
// self-checking bench for the reset and clock controller
module rcc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, er, sleep_mode, low_power_mode;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, w;
  logic [10:0] req;
  logic [3:0] src;
  wire [31:0] prdata;
  wire pready, pslverr, pu;
  wire [4:0] rs, ck;
  wire [26:0] apf;
  int num_errors, checks, i;
  realtime p;
  // stand-in sources slow enough for the pin samplers
  realtime hp [4] = '{100.0, 80.0, 120.0, 140.0};
  logic [7:0] cd [13] = '{8'h10, 8'h13, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0d, 8'h11,
    8'h0f, 8'h01, 8'h03, 8'h0c};
  int lv [13] = '{3, 3, 2, 2, 2, 2, 1, 1, 1, 3, 4, 2, 1};
  int cf [9] = '{'h110, 'h111, 'h112, 'h100, 'h101, 'h300, 'h301, 'h200, 'h000};

  rcc_top i_rcc_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_clk(src[0]), .pll_clk(src[1]), .osc_8mhz_clock(src[2]), .audio_pll_clock(src[3]),
    .rwdt_sys_rst(req[0]), .glitch_rst(req[1]), .sleep_wake_rst(req[2]),
    .mwdt0_glb_rst(req[3]), .mwdt1_glb_rst(req[4]), .rwdt_core_rst(req[5]),
    .mwdt0_cpu_rst(req[6]), .rwdt_cpu_rst(req[7]), .mwdt1_cpu_rst(req[8]),
    .brownout_det(req[9]), .super_wdt_rst(req[10]), .sleep_mode(sleep_mode),
    .low_power_mode(low_power_mode), .cpu_rst_n(rs[0]), .core_rst_n(rs[1]),
    .sys_rst_n(rs[2]), .chip_rst_n(rs[3]), .mem_rst_n(rs[4]), .cpu_clock(ck[0]),
    .apb_clock(ck[1]), .ref_tick(ck[2]), .led_pwm_clock(ck[3]),
    .osc_8mhz_div256_clock(ck[4]), .audio_pll_power_on(pu), .fraction_low(apf[7:0]),
    .fraction_high(apf[15:8]), .integer_part(apf[21:16]), .audio_pll_out_div(apf[26:22])
  );

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    src = 4'h0;
    fork
      forever #(hp[0]) src[0] = ~src[0];
      forever #(hp[1]) src[1] = ~src[1];
      forever #(hp[2]) src[2] = ~src[2];
      forever #(hp[3]) src[3] = ~src[3];
    join
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // periods are quantised to pclk, hence the tolerance
  task automatic chk_p(input realtime got, input realtime exp, input string m);
    checks++;
    if (got < exp - 30.0 || got > exp + 30.0) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %0.1f exp %0.1f", $time, m, got, exp);
    end
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dv);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dv;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_up();
    int k;
    for (k = 0; k < 80 && rs !== 5'h1f; k++) @(posedge pclk);
    #1;
    chk(32'(rs), 32'h1f, "release");
  endtask
  task automatic hit(input int n, input int l, input logic [7:0] c);
    logic [4:0] seen;
    int k;
    seen = 5'h1f;
    if (n < 11) begin
      @(posedge pclk);
      req[n] <= 1'b1;
      repeat (n > 8 ? 5 : 1) @(posedge pclk);
      req[n] <= 1'b0;
    end else begin
      apb(1'b1, 12'h010, 32'h1 << (n - 11));
    end
    for (k = 0; k < 10; k++) begin
      #1;
      seen = seen & rs;
      @(posedge pclk);
    end
    chk(32'(seen), 32'({l < 4, l < 4, l < 3, l < 2, 1'b0}), "scope");
    wait_up();
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(rd[5:0]), 32'(c), "cause");
    apb(1'b1, 12'h014, 32'h3f);
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(rd[5:0]), 32'(c), "cause kept");
  endtask
  task automatic meas(input int sg, input int n, input int lim);
    realtime t0;
    int e, k;
    logic pv;
    e = 0;
    t0 = 0;
    pv = ck[sg];
    for (k = 0; k < lim && e < n + 2; k++) begin
      @(posedge pclk);
      #1;
      if (ck[sg] === 1'b1 && pv === 1'b0) begin
        e++;
        if (e == 2) t0 = $realtime;
      end
      pv = ck[sg];
    end
    p = (e == n + 2) ? ($realtime - t0) / n : 0.0;
  endtask
  task automatic setclk(input int sl, input int pf, input int pr, input int pd, input int l);
    int k;
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'(pd));
    apb(1'b1, 12'h000, 32'(l * 32 + pr * 8 + pf * 4 + sl));
    for (k = 0; k < 400; k++) begin
      apb(1'b0, 12'h014, 32'h0);
      if (rd[7:6] === 2'(sl)) break;
    end
    chk(32'(rd[7:6]), 32'(sl), "source");
  endtask
  function automatic realtime cpu_p(int sl, int pf, int pr, int pd);
    int n;
    case (sl)
      1: n = pf ? (pr == 0 ? 6 : pr == 1 ? 3 : 2) : (pr == 0 ? 4 : 2);
      3: n = pr == 0 ? 4 : 2;
      default: n = pd + 1;
    endcase
    return n * 2 * hp[sl];
  endfunction
  task automatic ckrun(input int sl, input int pf, input int pr, input int pd);
    setclk(sl, pf, pr, pd, 0);
    meas(0, 3, 2000);
    chk_p(p, cpu_p(sl, pf, pr, pd), "cpu");
    meas(1, 2, 2000);
    chk_p(p, sl == 1 ? (pf ? 12 : 8) * hp[1] : (sl == 3 ? 2 : 1) * cpu_p(sl, pf, pr, pd),
      "bus");
    meas(2, 1, 2000);
    chk_p(p, sl == 2 ? 16 * hp[2] : 80 * hp[0], "tick");
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, sleep_mode, low_power_mode} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    req = 11'h0;
    num_errors = 0;
    checks = 0;
    void'($urandom(32'h58cd5f25));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    wait_up();
    apb(1'b0, 12'h014, 32'h0);
    chk(32'(rd[5:0]), 32'h01, "power-on cause");
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1, "divider default");
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h0727, "tick defaults");
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(er), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    for (i = 0; i < 13; i++) hit(i, lv[i], cd[i]);
    apb(1'b1, 12'h010, 32'h4);
    hit(9, 4, 8'h01);
    for (i = 0; i < 9; i++) ckrun(cf[i] >> 8, (cf[i] >> 4) & 1, cf[i] & 3, 1);
    repeat (5) ckrun($urandom % 4, $urandom % 2, $urandom % 3, $urandom % 6);
    for (i = 0; i < 4; i++) begin
      setclk(0, 0, 0, 1, i);
      meas(3, 2, 300);
      chk_p(p, i == 0 ? 0.0 : i == 1 ? 400.0 : i == 2 ? 240.0 : 200.0, "led");
    end
    @(posedge pclk);
    low_power_mode <= 1'b1;
    setclk(0, 0, 0, 1, 2);
    meas(3, 2, 300);
    chk_p(p, 240.0, "led low power");
    meas(1, 2, 300);
    chk_p(p, 0.0, "bus gated");
    meas(4, 1, 20000);
    chk_p(p, 512 * hp[2], "slow osc");
    for (i = 0; i < 8; i++) begin
      w = {3'h0, 2'(i), 27'($urandom)};
      w[21:16] = 6'h05 + 6'($urandom % 3);
      apb(1'b1, 12'h00c, w);
      sleep_mode <= i[2];
      repeat (4) @(posedge pclk);
      #1;
      chk(32'(pu), 32'(!i[1] && (i[0] || !i[2])), "pll power");
      chk(32'(apf), 32'(w[26:0]), "pll fields");
    end
    close_out();
  end
  initial begin
    #1800us;
    num_errors++;
    close_out();
  end
endmodule // rcc_top_tb
